//--- core/mqbm_pkg.sv
// Shared constants for the bus-matching packet queue
package mqbm_pkg;
	localparam int LANE_W = 9;
	localparam int DATA_W = 36;
	// Width-select codes, latched once after master reset
	localparam logic [3:0] WS_36_36 = 4'h0;
	localparam logic [3:0] WS_36_18 = 4'h1;
	localparam logic [3:0] WS_36_9 = 4'h2;
	localparam logic [3:0] WS_18_36 = 4'h3;
	localparam logic [3:0] WS_9_36 = 4'h4;
	localparam logic [3:0] WS_18_18 = 4'h5;
	localparam logic [3:0] WS_18_9 = 4'h6;
	localparam logic [3:0] WS_9_18 = 4'h7;
	localparam logic [3:0] WS_9_9 = 4'h9;
	// Port widths in 9-bit lanes
	localparam logic [2:0] LANES_36 = 3'h4;
	localparam logic [2:0] LANES_18 = 3'h2;
	localparam logic [2:0] LANES_9 = 3'h1;
	// Marker bit positions
	localparam int MK36_END = 35;
	localparam int MK36_START = 34;
	localparam int MK36_NEAR_END = 33;
	localparam int MK36_NEAR_START = 32;
	localparam int MK18_END = 17;
	localparam int MK18_START = 16;
	localparam int MK9_MARK = 8;
	// APB register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_LEVEL = 8'h08;
	localparam logic [7:0] ADDR_AE_THR = 8'h0C;
	localparam logic [7:0] ADDR_AF_THR = 8'h10;
	// Field positions
	localparam int CTRL_PKT_MODE = 0;
	localparam int ST_FULL_N = 0;
	localparam int ST_AF_N = 1;
	localparam int ST_EMPTY_N = 2;
	localparam int ST_AE_N = 3;
	localparam int ST_PR_N = 4;
	localparam int ST_PROG = 5;
	localparam int ST_MODE_LSB = 8;
	localparam int LVL_READY_LSB = 16;
	// Reset values
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [7:0] AE_THR_RESET = 8'h04;
	localparam logic [7:0] AF_THR_RESET = 8'h04;
	// Edges after reset release before the width code is taken
	localparam logic [1:0] CFG_SETTLE = 2'h3;
endpackage

//--- core/mqbm_lane_fifo.sv
// Lane-granular storage: pushes and pops 1, 2 or 4 nine-bit lanes
module mqbm_lane_fifo
	import mqbm_pkg::*;
#(
	parameter int DEPTH = 1024
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [2:0] push_lanes,
	input wire logic [DATA_W-1:0] push_data,
	input wire logic [2:0] pop_lanes,
	output logic [DATA_W-1:0] pop_data,
	output logic [$clog2(DEPTH):0] count
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} mqbm_fifo_t;

	mqbm_fifo_t s;
	mqbm_fifo_t next_s;
	logic [LANE_W-1:0] mem [DEPTH];

	always_comb begin
		next_s = s;
		next_s.wp = s.wp + AW'(push_lanes);
		next_s.rp = s.rp + AW'(pop_lanes);
		next_s.cnt = s.cnt + (AW + 1)'(push_lanes) - (AW + 1)'(pop_lanes);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// First lane lands at the lowest address, so it leaves first
	// One writer process: the array may have only one driver
	always_ff @(posedge clk) begin
		for (int i = 0; i < 4; i++) begin
			if (3'(i) < push_lanes) begin
				mem[s.wp + AW'(i)] <= push_data[i*LANE_W +: LANE_W];
			end
		end
	end

	for (genvar i = 0; i < 4; i++) begin : g_lane
		assign pop_data[i*LANE_W +: LANE_W] = mem[s.rp + AW'(i)];
	end

	assign count = s.cnt;
endmodule

//--- core/mqbm_core.sv
// Bus-matching packet queue with width conversion and marker placement
// Contract
// (R01) 36-bit word leaves as four 9-bit words
// (R02) 36-to-9: bytes carry start, near-start, near-end, end
// (R03) Writer never marks start and end together
// (R04) 18-to-36 joins two words, markers 35..32
// (R05) 9-to-36 joins four words, markers 35..32
// (R06) 18-to-18: bit 17 end, bit 16 start
// (R07) 18-to-9 splits each word in two
// (R08) 9-to-18 joins two words, bits 17/16
// (R09) 9-to-9: even bit 8 start, odd end
// (R10) Writer keeps packets at least four words
// (R11) Width code latched at reset selects widths
// (R12) Narrow words packed little-endian
// (R13) Full flags counted in write words
// (R14) Empty flags counted in read words
// (R15) One width pair serves every queue
// (R16) Agents wait for programming done low
// (R17) Packet mode holds reads until packet complete
// (R18) Packet ready falls no later than empty
// (R19) Repeated start or end markers ignored
// (R20) 36-to-18: even halves start, odd halves end
// (R21) Unknown width codes fall back to 36/36
module mqbm_core
	import mqbm_pkg::*;
#(
	parameter int DEPTH_LANES = 1024
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] width_select,
	input wire logic wr_en,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic rd_en,
	output logic [DATA_W-1:0] rd_data,
	output logic rd_valid,
	output logic queue_full_n,
	output logic almost_full_n,
	output logic queue_empty_n,
	output logic almost_empty_n,
	output logic packet_ready_n,
	output logic program_done_out
);
	localparam int CW = $clog2(DEPTH_LANES) + 1;

	typedef enum logic [1:0] {
		ST_CFG = 2'b01,
		ST_RUN = 2'b10
	} mqbm_state_t;

	typedef struct packed {
		mqbm_state_t st;
		logic [1:0] settle;
		logic [3:0] ws_s1;
		logic [3:0] ws_s2;
		logic [3:0] mode;
		logic [2:0] kw;
		logic [2:0] kr;
		logic pkt_mode;
		logic [7:0] ae_thr;
		logic [7:0] af_thr;
		logic [DATA_W-1:0] frame;
		logic [1:0] flo;
		logic in_pkt;
		logic [CW-1:0] pend;
		logic [CW-1:0] ready;
		logic [DATA_W-1:0] rd_data;
		logic rd_valid;
		logic full_n;
		logic af_n;
		logic empty_n;
		logic ae_n;
		logic pr_n;
		logic prog;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} mqbm_core_t;

	mqbm_core_t s;
	mqbm_core_t next_s;
	logic [2:0] push_lanes;
	logic [2:0] pop_lanes;
	logic [DATA_W-1:0] push_data;
	logic [DATA_W-1:0] pop_data;
	logic [CW-1:0] count;

	// Write and read widths for a width code
	function automatic logic [5:0] decode(input logic [3:0] code);
		unique case (code)
			WS_36_36: decode = {LANES_36, LANES_36};
			WS_36_18: decode = {LANES_36, LANES_18};
			WS_36_9: decode = {LANES_36, LANES_9};
			WS_18_36: decode = {LANES_18, LANES_36};
			WS_18_18: decode = {LANES_18, LANES_18};
			WS_18_9: decode = {LANES_18, LANES_9};
			WS_9_36: decode = {LANES_9, LANES_36};
			WS_9_18: decode = {LANES_9, LANES_18};
			WS_9_9: decode = {LANES_9, LANES_9};
			default: decode = {LANES_36, LANES_36}; // see (R21)
		endcase
	endfunction

	// Moves the stored markers to where the narrow reader expects them
	function automatic logic [DATA_W-1:0] place_marks(
		input logic [DATA_W-1:0] w,
		input logic [2:0] kr
	);
		place_marks = w;
		if (kr == LANES_9) begin
			place_marks[MK9_MARK] = w[MK36_START]; // see (R02)
			place_marks[LANE_W + MK9_MARK] = w[MK36_NEAR_START];
			place_marks[2*LANE_W + MK9_MARK] = w[MK36_NEAR_END];
			place_marks[MK36_START] = w[MK9_MARK];
			place_marks[MK36_NEAR_START] = w[LANE_W + MK9_MARK];
			place_marks[MK36_NEAR_END] = w[2*LANE_W + MK9_MARK];
		end else if (kr == LANES_18) begin
			place_marks[MK18_START] = w[MK36_NEAR_START]; // see (R20)
			place_marks[MK18_END] = w[MK36_START];
			place_marks[MK36_START] = w[MK36_NEAR_END];
			place_marks[MK36_NEAR_START] = w[MK18_START];
			place_marks[MK36_NEAR_END] = w[MK18_END];
		end
	endfunction

	function automatic logic [CW-1:0] scale(
		input logic [7:0] thr,
		input logic [2:0] k
	);
		scale = CW'(thr);
		if (k == LANES_36) begin
			scale = CW'({thr, 2'b00});
		end else if (k == LANES_18) begin
			scale = CW'({thr, 1'b0});
		end
	endfunction

	function automatic logic [31:0] read_reg(
		input mqbm_core_t c,
		input logic [7:0] a,
		input logic [CW-1:0] lvl
	);
		read_reg = 32'h0000_0000;
		unique case (a)
			ADDR_CTRL: read_reg[CTRL_PKT_MODE] = c.pkt_mode;
			ADDR_STATUS: begin
				read_reg[ST_FULL_N] = c.full_n;
				read_reg[ST_AF_N] = c.af_n;
				read_reg[ST_EMPTY_N] = c.empty_n;
				read_reg[ST_AE_N] = c.ae_n;
				read_reg[ST_PR_N] = c.pr_n;
				read_reg[ST_PROG] = c.prog;
				read_reg[ST_MODE_LSB +: 4] = c.mode;
			end
			ADDR_LEVEL: begin
				read_reg[CW-1:0] = lvl;
				read_reg[LVL_READY_LSB +: CW] = c.ready;
			end
			ADDR_AE_THR: read_reg[7:0] = c.ae_thr;
			ADDR_AF_THR: read_reg[7:0] = c.af_thr;
			default: read_reg = 32'h0000_0000;
		endcase
	endfunction

	always_comb begin
		logic [2:0] kf;
		logic [2:0] lo;
		logic do_wr;
		logic do_rd;
		logic done;
		logic mk_start;
		logic mk_end;
		logic [CW-1:0] seg;
		logic [CW-1:0] cnt_n;
		logic [CW-1:0] free_n;
		logic [CW-1:0] avail;
		logic [CW-1:0] avail_n;
		logic [DATA_W-1:0] nf;
		logic [5:0] widths;
		kf = 3'h0;
		lo = 3'h0;
		do_wr = 1'b0;
		do_rd = 1'b0;
		done = 1'b0;
		mk_start = 1'b0;
		mk_end = 1'b0;
		seg = '0;
		cnt_n = '0;
		free_n = '0;
		avail = '0;
		avail_n = '0;
		nf = '0;
		widths = '0;
		next_s = s;
		next_s.ws_s1 = width_select;
		next_s.ws_s2 = s.ws_s1;
		next_s.rd_valid = 1'b0;

		// Width code is caught once after release, then frozen
		unique case (s.st)
			ST_CFG: begin
				next_s.settle = s.settle + 2'h1;
				if (s.settle == CFG_SETTLE) begin
					widths = decode(s.ws_s2);
					next_s.mode = s.ws_s2; // see (R11)
					next_s.kw = widths[5:3]; // see (R15)
					next_s.kr = widths[2:0];
					next_s.prog = 1'b0;
					next_s.st = ST_RUN;
				end
			end
			ST_RUN: begin
			end
		endcase

		// Packet tracking looks at frames of the wider port's width, or two lanes when both ports are 9-bit
		kf = (s.kw > s.kr) ? s.kw : s.kr;
		if (s.kw == LANES_9 && s.kr == LANES_9) begin
			kf = LANES_18;
		end
		avail = s.pkt_mode ? s.ready : count;
		do_wr = (s.st == ST_RUN) && wr_en &&
			(CW'(DEPTH_LANES) - count >= CW'(s.kw)); // see (R13)
		do_rd = (s.st == ST_RUN) && rd_en &&
			(avail >= CW'(s.kr)); // see (R17)

		lo = {1'b0, s.flo};
		nf = s.frame;
		for (int i = 0; i < 4; i++) begin
			if (3'(i) >= lo && 3'(i) < lo + s.kw) begin
				nf[i*LANE_W +: LANE_W] =
					wr_data[(i - int'(lo))*LANE_W +: LANE_W]; // see (R12)
			end
		end
		done = (lo + s.kw) == kf;
		if (kf == LANES_36) begin
			mk_start = nf[MK36_START]; // see (R04) (R05)
			mk_end = nf[MK36_END];
		end else if (s.kw == LANES_9 && s.kr == LANES_9) begin
			mk_start = nf[MK9_MARK]; // see (R09)
			mk_end = nf[LANE_W + MK9_MARK];
		end else begin
			mk_start = nf[MK18_START]; // see (R06) (R08)
			mk_end = nf[MK18_END];
		end

		push_data = '0;
		push_lanes = 3'h0;
		cnt_n = count;
		if (do_wr) begin
			push_lanes = s.kw;
			push_data = wr_data;
			if (s.kw == LANES_36 && s.pkt_mode) begin
				push_data = place_marks(wr_data, s.kr); // see (R01)
			end
			next_s.frame = nf;
			next_s.flo = done ? 2'h0 : 2'(lo + s.kw);
			seg = s.pend + CW'(s.kw);
			next_s.pend = seg;
			if (done) begin
				// Extra starts inside a packet and stray ends do nothing
				if (!s.in_pkt && mk_start) begin
					next_s.in_pkt = 1'b1; // see (R19)
				end
				if ((s.in_pkt || mk_start) && mk_end) begin
					next_s.ready = s.ready + seg;
					next_s.pend = '0;
					next_s.in_pkt = 1'b0;
				end
			end
		end

		pop_lanes = 3'h0;
		if (do_rd) begin
			pop_lanes = s.kr; // see (R07)
			next_s.rd_valid = 1'b1;
			for (int i = 0; i < 4; i++) begin
				next_s.rd_data[i*LANE_W +: LANE_W] = (3'(i) < s.kr) ?
					pop_data[i*LANE_W +: LANE_W] : '0;
			end
		end
		if (do_rd && next_s.ready >= CW'(s.kr)) begin
			next_s.ready = next_s.ready - CW'(s.kr);
		end else if (do_rd) begin
			next_s.ready = '0;
		end
		cnt_n = count + CW'(push_lanes) - CW'(pop_lanes);
		free_n = CW'(DEPTH_LANES) - cnt_n;
		avail_n = s.pkt_mode ? next_s.ready : cnt_n;

		// Flags share one update so packet ready never trails empty in packet mode
		next_s.full_n = free_n >= CW'(s.kw); // see (R13)
		next_s.af_n = free_n >= scale(s.af_thr, s.kw);
		next_s.empty_n = avail_n >= CW'(s.kr); // see (R14)
		next_s.ae_n = avail_n > scale(s.ae_thr, s.kr);
		next_s.pr_n = !(next_s.ready >= CW'(s.kr)); // see (R18)

		// Zero-wait slave: read data is formed during the setup cycle
		if (psel && !penable) begin
			next_s.prdata = read_reg(s, paddr, count);
			next_s.pslverr = !(paddr == ADDR_CTRL || paddr == ADDR_STATUS ||
				paddr == ADDR_LEVEL || paddr == ADDR_AE_THR ||
				paddr == ADDR_AF_THR);
		end
		next_s.pready = 1'b1;
		if (psel && penable && pwrite) begin
			unique case (paddr)
				ADDR_CTRL: next_s.pkt_mode = pwdata[CTRL_PKT_MODE];
				ADDR_AE_THR: next_s.ae_thr = pwdata[7:0];
				ADDR_AF_THR: next_s.af_thr = pwdata[7:0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.st <= ST_CFG;
			s.kw <= LANES_36;
			s.kr <= LANES_36;
			s.pkt_mode <= CTRL_RESET[CTRL_PKT_MODE];
			s.ae_thr <= AE_THR_RESET;
			s.af_thr <= AF_THR_RESET;
			s.af_n <= 1'b1;
			s.pr_n <= 1'b1;
			s.prog <= 1'b1; // see (R16)
		end else begin
			s <= next_s;
		end
	end

	mqbm_lane_fifo #(
		.DEPTH(DEPTH_LANES)
	) u_store (
		.clk(pclk),
		.rst_n(presetn),
		.push_lanes(push_lanes),
		.push_data(push_data),
		.pop_lanes(pop_lanes),
		.pop_data(pop_data),
		.count(count)
	);

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign rd_data = s.rd_data;
	assign rd_valid = s.rd_valid;
	assign queue_full_n = s.full_n;
	assign almost_full_n = s.af_n;
	assign queue_empty_n = s.empty_n;
	assign almost_empty_n = s.ae_n;
	assign packet_ready_n = s.pr_n;
	assign program_done_out = s.prog;
endmodule

//--- verification/mqbm_core_sva.sv
// Port-level assertions for the bus-matching packet queue
module mqbm_core_sva
	import mqbm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [3:0] width_select,
	input wire logic rd_en,
	input wire logic [DATA_W-1:0] rd_data,
	input wire logic rd_valid,
	input wire logic queue_full_n,
	input wire logic almost_full_n,
	input wire logic queue_empty_n,
	input wire logic packet_ready_n,
	input wire logic program_done_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] ws;
	logic rl9;
	logic rl18;
	// Tracks the code only while configuring, as the core does
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ws <= 4'h0;
		else if (program_done_out)
			ws <= width_select;
	end
	assign rl9 = ws == WS_36_9 || ws == WS_18_9 || ws == WS_9_9;
	assign rl18 = ws == WS_36_18 || ws == WS_18_18 || ws == WS_9_18;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_prog_latched: assert property (!program_done_out |=> !program_done_out)
		else $error("programming done rose again");
	a_cfg_time: assert property ($rose(presetn) |-> ##[1:6] !program_done_out)
		else $error("width setup not finished in time");
	a_x9_upper: assert property (rd_valid && rl9 |-> rd_data[35:9] == '0)
		else $error("narrow read carries upper bits");
	a_x18_upper: assert property (rd_valid && rl18 |-> rd_data[35:18] == '0)
		else $error("half read carries upper bits");
	a_empty_holds: assert property (rd_en && !queue_empty_n && !program_done_out
		|=> !rd_valid)
		else $error("read served while empty");
	a_read_served: assert property (rd_en && queue_empty_n && !program_done_out
		|=> rd_valid)
		else $error("read refused while not empty");
	a_pr_no_later: assert property (!packet_ready_n |-> queue_empty_n)
		else $error("packet ready while empty");
	a_full_af: assert property (!queue_full_n && !program_done_out
		|-> !almost_full_n)
		else $error("full without almost full");
	a_unmapped_err: assert property (psel && penable && paddr > ADDR_AF_THR
		|-> pslverr && pready)
		else $error("unmapped access without error");
	c_pkt_ready: cover property (!packet_ready_n);
	c_full_left: cover property ($rose(queue_full_n));
	c_x9_read: cover property (rd_valid && rl9);
endmodule

bind mqbm_core mqbm_core_sva mqbm_core_sva_inst (.pclk, .presetn, .psel,
	.penable, .paddr, .pready, .pslverr, .width_select, .rd_en, .rd_data,
	.rd_valid, .queue_full_n, .almost_full_n, .queue_empty_n,
	.packet_ready_n, .program_done_out);

//--- verification/mqbm_writer.sv
// Write-side agent model: offers one word at a time to the queue
module mqbm_writer
	import mqbm_pkg::*;
(
	input wire logic pclk,
	input wire logic program_done_out,
	input wire logic queue_full_n,
	output logic wr_en,
	output logic [DATA_W-1:0] wr_data
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		wr_en = 1'h0;
		wr_data = 36'h0_0000_0000;
	end
	task automatic push(logic [DATA_W-1:0] w);
		@(posedge pclk);
		while (program_done_out) @(posedge pclk);
		wr_en <= 1'h1;
		wr_data <= w;
		do @(posedge pclk); while (!queue_full_n);
	endtask
	// Released data must not look like a held word
	task automatic idle();
		wr_en <= 1'h0;
		wr_data <= ~wr_data;
	endtask
endmodule

//--- verification/test_mqbm_core.sv
// Self-checking bench for the bus-matching packet queue
module test_mqbm_core
	import mqbm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
	logic pwrite = 1'h0, rd_en = 1'h0, pready, pslverr, rd_valid, wr_en;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic [3:0] width_select = 4'h0;
	logic [DATA_W-1:0] wr_data, rd_data;
	logic queue_full_n, almost_full_n, queue_empty_n;
	logic almost_empty_n, packet_ready_n, program_done_out;
	int error_cnt = 0, tests_run = 0;
	logic [3:0] codes [10] = '{WS_36_36, WS_36_18, WS_36_9, WS_18_36,
		WS_18_18, WS_18_9, WS_9_36, WS_9_18, WS_9_9, 4'hF};
	int wls [10] = '{4, 4, 4, 2, 2, 2, 1, 1, 1, 4};
	int rls [10] = '{4, 2, 1, 4, 2, 1, 4, 2, 1, 4};
	always #2.5 pclk = ~pclk;
	// Small depth keeps the fill test short
	mqbm_core #(.DEPTH_LANES(64)) mqbm_core_inst (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.width_select, .wr_en, .wr_data, .rd_en, .rd_data, .rd_valid,
		.queue_full_n, .almost_full_n, .queue_empty_n, .almost_empty_n,
		.packet_ready_n, .program_done_out);
	mqbm_writer mqbm_writer_inst (.pclk, .program_done_out, .queue_full_n,
		.wr_en, .wr_data);
	task automatic chk(string n, logic [35:0] e, logic [35:0] g);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic end_sim();
		if (error_cnt == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic rst(logic [3:0] c);
		presetn <= 1'h0;
		width_select <= c;
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		do @(posedge pclk); while (program_done_out);
		@(posedge pclk);
	endtask
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (!pready);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic put(logic [35:0] w);
		mqbm_writer_inst.push(w);
		mqbm_writer_inst.idle();
		@(negedge pclk);
	endtask
	task automatic pop(logic v, logic [35:0] e);
		@(posedge pclk);
		rd_en <= 1'h1;
		@(posedge pclk);
		rd_en <= 1'h0;
		@(negedge pclk);
		chk("rd_valid", {35'h0, v}, {35'h0, rd_valid});
		if (v)
			chk("rd_data", e, rd_data);
	endtask
	task automatic t_regs();
		logic [31:0] q;
		logic e;
		rst(WS_9_9);
		apb(1'h0, ADDR_STATUS, 32'h0, q, e);
		chk("status", 36'h0_0000_0913, {4'h0, q});
		apb(1'h0, ADDR_AE_THR, 32'h0, q, e);
		chk("ae_thr", {28'h0, AE_THR_RESET}, {4'h0, q});
		apb(1'h0, 8'h14, 32'h0, q, e);
		chk("pslverr", 36'h1, {35'h0, e});
		apb(1'h1, ADDR_CTRL, 32'h0000_0001, q, e);
		apb(1'h0, ADDR_CTRL, 32'h0, q, e);
		chk("ctrl", 36'h1, {4'h0, q});
	endtask
	task automatic t_conv(int i);
		logic [35:0] s = 36'h8_7654_3210;
		logic [35:0] m;
		rst(codes[i]);
		m = ~(36'hF_FFFF_FFFF << (wls[i] * 9));
		for (int k = 0; k < 4; k += wls[i]) begin
			put((s >> (k * 9)) & m);
			chk("empty_n", {35'h0, k + wls[i] >= rls[i]},
				{35'h0, queue_empty_n});
		end
		m = ~(36'hF_FFFF_FFFF << (rls[i] * 9));
		for (int k = 0; k < 4; k += rls[i])
			pop(1'h1, (s >> (k * 9)) & m);
	endtask
	task automatic t_full();
		rst(WS_36_9);
		repeat (16) put(36'h0_0000_0000);
		chk("full_n", 36'h0, {35'h0, queue_full_n});
		chk("af_n", 36'h0, {35'h0, almost_full_n});
		chk("ae_n", 36'h1, {35'h0, almost_empty_n});
		for (int k = 1; k <= 4; k++) begin
			pop(1'h1, 36'h0);
			chk("full_n", {35'h0, k == 4}, {35'h0, queue_full_n});
		end
	endtask
	task automatic t_pkt();
		logic [31:0] q;
		logic e;
		rst(WS_36_9);
		apb(1'h1, ADDR_CTRL, 32'h0000_0001, q, e);
		put(36'h5_0000_00A5);
		put(36'h4_0000_0000);
		put(36'h0_0000_0000);
		pop(1'h0, 36'h0);
		put(36'hA_0000_0000);
		chk("pr_n", 36'h0, {35'h0, packet_ready_n});
		for (int k = 0; k < 16; k++)
			pop(1'h1, k == 0 ? 36'h1A5 :
				(k inside {1, 4, 14, 15}) ? 36'h100 : 36'h0);
		chk("pr_n", 36'h1, {35'h0, packet_ready_n});
	endtask
	initial begin
		t_regs();
		for (int i = 0; i < 10; i++)
			t_conv(i);
		t_full();
		t_pkt();
		end_sim();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		end_sim();
	end
endmodule
